// ### rtl/aets_pkg.sv
// Constants, field layout and types of the external trigger sequencer
package aets_pkg;

  // ==========================================================
  // Register offsets (byte addresses on the bus)
  localparam logic [31:0] AETS_MODE_A_OFS  = 32'h0000_0000;
  localparam logic [31:0] AETS_MODE_B_OFS  = 32'h0000_0004;
  localparam logic [31:0] AETS_PORT_FN_OFS = 32'h0000_0008;
  localparam logic [31:0] AETS_STATUS_OFS  = 32'h0000_000C;
  localparam logic [31:0] AETS_RES_BASE    = 32'h0000_0020;
  localparam int          AETS_RES_LSB     = 5;

  // ==========================================================
  // Field positions
  localparam int AETS_A_CH_LSB   = 0;  // Channel / last scan channel
  localparam int AETS_A_SCAN     = 3;  // 1 = scan, 0 = select
  localparam int AETS_A_FOURBUF  = 4;  // Select mode: four buffers
  localparam int AETS_A_EN       = 7;  // Converter enable
  localparam int AETS_B_FOURTRIG = 0;  // Four triggers vs one
  localparam int AETS_ST_ACTIVE  = 0;
  localparam int AETS_ST_HIGH    = 1;
  localparam int AETS_ST_CNT_LSB = 4;
  localparam int AETS_ST_CH_LSB  = 8;

  // ==========================================================
  // Widths, reset values and counts
  localparam int AETS_NTRIG = 4;
  localparam int AETS_NCH   = 8;
  localparam int AETS_RES_W = 10;
  localparam logic [7:0] AETS_MODE_A_RST  = 8'h00;
  localparam logic       AETS_MODE_B_RST  = 1'b0;
  localparam logic [3:0] AETS_PORT_FN_RST = 4'h0;
  localparam logic [2:0] AETS_CNT_FULL    = 3'h4;  // Four-trigger set
  localparam logic [2:0] AETS_LOW_LAST    = 3'h3;  // Top of low group
  localparam logic [2:0] AETS_HIGH_FIRST  = 3'h4;
  localparam logic [2:0] AETS_CH_ONE      = 3'h1;
  localparam logic [2:0] AETS_BUF_LAST    = 3'h3;

  // ==========================================================
  // Sequencer phase
  typedef enum logic [1:0] {
    AETS_IDLE,
    AETS_LOW,
    AETS_HIGH
  } aets_phase_t;

endpackage

// ### rtl/aets_edge_sync.sv
// One trigger pin: two-stage synchroniser and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module aets_edge_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic pin,
  output logic      pulse
);

  logic meta;
  logic sync;
  logic last;

  // ==========================================================
  // Synchroniser; only the second stage feeds the detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta  <= 1'b0;
      sync  <= 1'b0;
      last  <= 1'b0;
      pulse <= 1'b0;
    end else if (ce) begin
      meta  <= pin;
      sync  <= meta;
      last  <= sync;
      pulse <= enable & sync & ~last;
    end
  end

  pulse_single_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    pulse && ce |=> !pulse)
    else $error("trigger pulse lasted more than one cycle");

endmodule
`default_nettype wire

// ### rtl/aets_seq.sv
// External trigger A/D sequencer with AHB-Lite register slave
// ==========================================================
// Behaviour
// - External triggers convert channels 0-3; 4-7 only by scan continuation.
// - Select mode converts the one channel 0-3 given in mode register a.
// - One buffer, one trigger: pin 0 event converts once, done pulse.
// - New trigger aborts the running conversion and starts its own.
// - One buffer, four triggers: each conversion done pulse; set of four.
// - Four-trigger modes take pins in any order, repeating on each event.
// - Simultaneous triggers: lowest converted, others dropped and not counted.
// - Four buffers, one trigger: four back-to-back conversions into 0-3.
// - Four buffers, four triggers: pin k fills result k; done after four.
// - Scan ascends from channel 0 to last channel; ends early if low.
// - Full scan continues channels 4-7 internally after 0-3.
// - Scan channel n lands in result n; done after the last one.
// - Scan one trigger: pin 0 runs channels 0-3; next event restarts.
// - Trigger during high channels aborts and restarts at the low group.
// - Scan four triggers: pin k converts channel k.
// - Scan four triggers: a trigger after completion restarts the sequence.
// - Mode register b picks four-trigger or pin-0-only operation.
`timescale 1ns/1ps
`default_nettype none
module aets_seq
  import aets_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  ext_trigger_in_0,
  input  wire logic                  ext_trigger_in_1,
  input  wire logic                  ext_trigger_in_2,
  input  wire logic                  ext_trigger_in_3,
  input  wire logic                  conv_ready,
  input  wire logic [AETS_RES_W-1:0] conv_data,
  output logic                       conv_start,
  output logic      [2:0]            conv_channel,
  output logic                       conversion_done_irq,
  output logic                       conv_active
);

  // ==========================================================
  // Declarations
  logic [7:0]            conv_mode_reg_a;
  logic                  conv_mode_reg_b;
  logic [3:0]            port_func_select;
  logic [AETS_RES_W-1:0] conv_result_n [AETS_NCH];
  aets_phase_t           phase;
  aets_phase_t           next_phase;
  logic [2:0]            dest;
  logic [2:0]            cnt;
  logic                  next_start;
  logic [2:0]            next_ch;
  logic [2:0]            next_dest;
  logic [2:0]            next_cnt;
  logic                  next_irq;
  logic                  wr_pend;
  logic [31:0]           wr_addr;
  wire  [3:0]            trig_pin;
  wire  [3:0]            trig_pulse;

  // ==========================================================
  // Mode fields
  wire       mode_en   = conv_mode_reg_a[AETS_A_EN];
  wire       scan      = conv_mode_reg_a[AETS_A_SCAN];
  wire       four_buf  = conv_mode_reg_a[AETS_A_FOURBUF];
  wire       four_trig = conv_mode_reg_b;
  wire [2:0] last_ch   = conv_mode_reg_a[AETS_A_CH_LSB +: 3];
  wire [2:0] sel_ch    = {1'b0, last_ch[1:0]};

  // ==========================================================
  // Trigger pins: one synchroniser each, gated by pin function
  assign trig_pin = {ext_trigger_in_3, ext_trigger_in_2,
                     ext_trigger_in_1, ext_trigger_in_0};

  genvar gi;
  generate
    for (gi = 0; gi < AETS_NTRIG; gi++) begin : g_pin
      aets_edge_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .enable  (port_func_select[gi]),
        .pin     (trig_pin[gi]),
        .pulse   (trig_pulse[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Trigger qualification and priority
  // Pin 0 only unless four-trigger; lowest pin wins a tie
  wire [3:0] trig_ok  = trig_pulse & (four_trig ? 4'hF : 4'h1)
                        & {4{mode_en}};
  wire       trig_any = |trig_ok;
  wire [1:0] trig_k   = trig_ok[0] ? 2'h0 :
                        trig_ok[1] ? 2'h1 :
                        trig_ok[2] ? 2'h2 : 2'h3;
  wire [2:0] first_ch = !scan ? sel_ch :
                        (four_trig ? {1'b0, trig_k} : 3'h0);
  wire [2:0] first_dest = scan ? first_ch :
                          (!four_buf ? sel_ch :
                           (four_trig ? {1'b0, trig_k} : 3'h0));
  wire [2:0] cnt_inc  = cnt + AETS_CH_ONE;
  wire [2:0] ch_inc   = conv_channel + AETS_CH_ONE;
  wire [2:0] dest_inc = dest + AETS_CH_ONE;
  wire       go_high  = last_ch > AETS_LOW_LAST;
  wire [2:0] low_last = go_high ? AETS_LOW_LAST : last_ch;
  wire [2:0] low_cnt  = low_last + AETS_CH_ONE;
  wire       low_done = four_trig ? (cnt_inc == low_cnt)
                                  : (conv_channel == low_last);
  wire       running  = phase != AETS_IDLE;
  wire       res_we   = conv_ready && running;

  // ==========================================================
  // Sequencer next state; a fresh trigger overrides everything
  always_comb begin
    logic finish;
    finish     = 1'b0;
    next_phase = phase;
    next_start = 1'b0;
    next_ch    = conv_channel;
    next_dest  = dest;
    next_cnt   = cnt;
    next_irq   = 1'b0;
    if (!mode_en) begin
      next_phase = AETS_IDLE;
      next_cnt   = '0;
    end else if (trig_any) begin
      next_start = 1'b1;
      next_phase = AETS_LOW;
      next_ch    = first_ch;
      next_dest  = first_dest;
      if (!four_trig || phase == AETS_HIGH) begin
        next_cnt = '0;
      end
    end else if (conv_ready) begin
      case (phase)
        AETS_LOW: begin
          if (!scan && !four_buf && !four_trig) begin
            finish = 1'b1;
          end else if (!scan && !four_buf) begin
            next_irq   = 1'b1;
            next_phase = AETS_IDLE;
            next_cnt   = (cnt_inc == AETS_CNT_FULL) ? '0 : cnt_inc;
          end else if (!scan && four_trig) begin
            next_cnt = cnt_inc;
            finish   = cnt_inc == AETS_CNT_FULL;
          end else if (!scan) begin
            if (dest == AETS_BUF_LAST) begin
              finish = 1'b1;
            end else begin
              next_start = 1'b1;
              next_dest  = dest_inc;
            end
          end else if (low_done && go_high) begin
            next_start = 1'b1;
            next_phase = AETS_HIGH;
            next_ch    = AETS_HIGH_FIRST;
            next_dest  = AETS_HIGH_FIRST;
            next_cnt   = '0;
          end else if (low_done) begin
            finish = 1'b1;
          end else if (four_trig) begin
            next_cnt = cnt_inc;
          end else begin
            next_start = 1'b1;
            next_ch    = ch_inc;
            next_dest  = ch_inc;
          end
        end
        AETS_HIGH: begin
          if (conv_channel == last_ch) begin
            finish = 1'b1;
          end else begin
            next_start = 1'b1;
            next_ch    = ch_inc;
            next_dest  = ch_inc;
          end
        end
        default: begin
          next_phase = AETS_IDLE;
        end
      endcase
    end
    if (finish) begin
      next_irq   = 1'b1;
      next_phase = AETS_IDLE;
      next_cnt   = '0;
    end
  end

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase               <= AETS_IDLE;
      conv_start          <= 1'b0;
      conv_channel        <= '0;
      dest                <= '0;
      cnt                 <= '0;
      conversion_done_irq <= 1'b0;
    end else if (ce) begin
      phase               <= next_phase;
      conv_start          <= next_start;
      conv_channel        <= next_ch;
      dest                <= next_dest;
      cnt                 <= next_cnt;
      conversion_done_irq <= next_irq;
    end
  end

  assign conv_active = running;

  // ==========================================================
  // Result store; an aborted conversion never reports ready,
  // so the register keeps its previous contents (zero after reset)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < AETS_NCH; i++) begin
        conv_result_n[i] <= '0;
      end
    end else if (ce && res_we) begin
      conv_result_n[dest] <= conv_data;
    end
  end

  // ==========================================================
  // Bus decode; zero wait states while ce is high, always OKAY
  wire addr_ok = hsel && htrans[1] && hready && ce;
  wire rd_req  = addr_ok && !hwrite;
  wire wr_req  = addr_ok && hwrite;
  wire [31:0] st_word = {21'h0, conv_channel, 1'b0, cnt, 2'h0,
                         phase == AETS_HIGH, running};
  wire is_res = haddr[31:AETS_RES_LSB] == AETS_RES_BASE[31:AETS_RES_LSB];
  wire [31:0] rd_word =
    is_res ? {22'h0, conv_result_n[haddr[AETS_RES_LSB-1:2]]} :
    (haddr == AETS_MODE_A_OFS)  ? {24'h0, conv_mode_reg_a} :
    (haddr == AETS_MODE_B_OFS)  ? {31'h0, conv_mode_reg_b} :
    (haddr == AETS_PORT_FN_OFS) ? {28'h0, port_func_select} :
    (haddr == AETS_STATUS_OFS)  ? st_word : 32'h0;

  assign hreadyout = ce;
  assign hresp     = 1'b0;

  // Read data captured in the address phase, write done in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata  <= '0;
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (ce) begin
      hrdata  <= rd_req ? rd_word : 32'h0;
      wr_pend <= wr_req;
      wr_addr <= haddr;
    end
  end

  // ==========================================================
  // Software registers; pin function bits should only change
  // while the converter is disabled, else a pin edge may fire
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_mode_reg_a  <= AETS_MODE_A_RST;
      conv_mode_reg_b  <= AETS_MODE_B_RST;
      port_func_select <= AETS_PORT_FN_RST;
    end else if (ce && wr_pend) begin
      if (wr_addr == AETS_MODE_A_OFS) begin
        conv_mode_reg_a <= hwdata[7:0];
      end
      if (wr_addr == AETS_MODE_B_OFS) begin
        conv_mode_reg_b <= hwdata[AETS_B_FOURTRIG];
      end
      if (wr_addr == AETS_PORT_FN_OFS) begin
        port_func_select <= hwdata[3:0];
      end
    end
  end

  // ==========================================================
  // Checks
  trig_starts_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && trig_any |=> conv_start && conv_active)
    else $error("accepted trigger did not start a conversion");

  select_chan_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && trig_any && !scan |=> conv_channel == $past(sel_ch))
    else $error("select mode converted the wrong channel");

  low_group_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    conv_start && phase != AETS_HIGH |-> !conv_channel[2])
    else $error("external trigger reached a high channel");

  lowest_wins_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && scan && four_trig && trig_ok[0] && trig_ok[1]
    |=> conv_channel == 3'h0)
    else $error("simultaneous triggers did not pick the lowest");

  done_idle_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    conversion_done_irq |-> !conv_active || $past(trig_any))
    else $error("done pulse left the active flag set");

  buf_walk_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && res_we && !trig_any && mode_en && !scan && four_buf
    && !four_trig && dest != AETS_BUF_LAST
    |=> conv_start && dest == $past(dest_inc))
    else $error("four-buffer run skipped a result register");

  high_cont_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && res_we && !trig_any && mode_en && scan && !four_trig
    && phase == AETS_LOW && conv_channel == AETS_LOW_LAST && go_high
    |=> conv_start && conv_channel == AETS_HIGH_FIRST)
    else $error("scan did not continue into channel four");

  high_abort_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && trig_any && scan && !four_trig && phase == AETS_HIGH
    |=> phase == AETS_LOW && conv_channel == 3'h0)
    else $error("trigger in high group did not restart scan");

  result_store_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && res_we |=> conv_result_n[$past(dest)] == $past(conv_data))
    else $error("result landed in the wrong register");

endmodule
`default_nettype wire

// ### verif/aets_far.sv
// Far-side model: trigger pins and a converter with adjustable latency
`timescale 1ns/1ps
`default_nettype none
module aets_far
  import aets_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  conv_start,
  input  wire logic [2:0]            conv_channel,
  output logic                       conv_ready,
  output logic      [AETS_RES_W-1:0] conv_data,
  output logic                       ext_trigger_in_0,
  output logic                       ext_trigger_in_1,
  output logic                       ext_trigger_in_2,
  output logic                       ext_trigger_in_3
);
  logic [3:0] pins;
  logic [6:0] seq;
  logic [2:0] ch;
  int         lat;
  int         cnt;

  // ==========================================================
  // Trigger pins
  assign {ext_trigger_in_3, ext_trigger_in_2} = pins[3:2];
  assign {ext_trigger_in_1, ext_trigger_in_0} = pins[1:0];

  initial begin
    pins = 4'h0;
    lat  = 6;
  end

  // One event per call; pins fall and stay low at least two cycles before any next one
  task automatic fire(input logic [3:0] m);
    @(posedge hclk);
    pins <= m;
    repeat (3) @(posedge hclk);
    pins <= 4'h0;
    @(posedge hclk);
  endtask

  // ==========================================================
  // Converter: a new start throws away the running one, so no stale ready
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt        <= 0;
      seq        <= 7'h00;
      ch         <= 3'h0;
      conv_ready <= 1'b0;
      conv_data  <= '0;
    end else begin
      conv_ready <= 1'b0;
      conv_data  <= ~conv_data;  // Not valid: toggles, never holds
      if (conv_start) begin
        cnt <= lat;
        ch  <= conv_channel;
      end else if (cnt == 1) begin
        conv_ready <= 1'b1;
        conv_data  <= {seq, ch};
        seq        <= seq + 7'h01;
        cnt        <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/aets_seq_test.sv
// Self-checking bench for the external trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module aets_seq_test
  import aets_pkg::*;
;
  logic                  hclk = 1'b0;
  logic                  hresetn, ce, hsel, hwrite, hready, hreadyout;
  logic                  hresp, conv_ready, conv_start;
  logic                  conversion_done_irq, conv_active;
  logic                  ext_trigger_in_0, ext_trigger_in_1;
  logic                  ext_trigger_in_2, ext_trigger_in_3;
  logic [1:0]            htrans;
  logic [2:0]            hsize, conv_channel, last_ch;
  logic [31:0]           haddr, hwdata, hrdata, rd;
  logic [AETS_RES_W-1:0] conv_data;
  logic [6:0]            s;
  int                    n_mismatch = 0;
  int                    compares = 0;
  int                    n_irq = 0;
  int                    n_start = 0;
  int                    ni;

  // ==========================================================
  // Clock, design, far side
  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;

  aets_seq u_aets_seq (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .ce                  (ce),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hready),
    .hrdata              (hrdata),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .ext_trigger_in_0    (ext_trigger_in_0),
    .ext_trigger_in_1    (ext_trigger_in_1),
    .ext_trigger_in_2    (ext_trigger_in_2),
    .ext_trigger_in_3    (ext_trigger_in_3),
    .conv_ready          (conv_ready),
    .conv_data           (conv_data),
    .conv_start          (conv_start),
    .conv_channel        (conv_channel),
    .conversion_done_irq (conversion_done_irq),
    .conv_active         (conv_active)
  );

  aets_far u_aets_far (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .conv_start       (conv_start),
    .conv_channel     (conv_channel),
    .conv_ready       (conv_ready),
    .conv_data        (conv_data),
    .ext_trigger_in_0 (ext_trigger_in_0),
    .ext_trigger_in_1 (ext_trigger_in_1),
    .ext_trigger_in_2 (ext_trigger_in_2),
    .ext_trigger_in_3 (ext_trigger_in_3)
  );

  // Counted on the falling edge so task reads never race the update
  always @(negedge hclk) begin
    if (conv_start === 1'b1) begin
      n_start++;
      last_ch = conv_channel;
    end
    if (conversion_done_irq === 1'b1) n_irq++;
  end

  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  function automatic logic cond(input int w);
    case (w)
      0: return hready;
      1: return conversion_done_irq;
      default: return conv_start && conv_channel == 3'h5;
    endcase
  endfunction

  // Bounded wait for ready, done pulse, or start of channel 5
  task automatic wait_on(input int w);
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
      if (k > 400) begin
        n_mismatch++;
        report_and_stop();
      end
    end while (cond(w) !== 1'b1);
  endtask

  // Single AHB-Lite word transfer; read data taken at the closing edge
  task automatic xfer(input logic [31:0] a, input logic w,
                      input logic [31:0] d);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_on(0);
    htrans <= 2'h0;
    hwdata <= d;
    wait_on(0);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    check(rd, e);
  endtask

  task automatic chk_res(input int n, input logic [6:0] q,
                         input logic [2:0] c);
    rdchk(AETS_RES_BASE + 32'(4 * n), {22'h0, q, c});
  endtask

  // ==========================================================
  // Main sequence
  int pa[4] = '{8, 2, 1, 4};
  int so[4] = '{0, 3, 1, 2};
  int pc[4] = '{4, 1, 8, 2};
  int sc[4] = '{1, 3, 0, 2};

  initial begin
    hresetn = 1'b0;
    ce      = 1'b1;
    hsel    = 1'b1;
    hsize   = 3'h2;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    cyc(5);
    hresetn <= 1'b1;
    // Reset values, read-only status, unmapped place
    rdchk(AETS_MODE_A_OFS, 32'h0);
    rdchk(AETS_MODE_B_OFS, 32'h0);
    rdchk(AETS_PORT_FN_OFS, 32'h0);
    // Deselected write must leave the mode untouched
    hsel <= 1'b0;
    wr(AETS_MODE_B_OFS, 32'h1);
    hsel <= 1'b1;
    rdchk(AETS_MODE_B_OFS, 32'h0);
    wr(AETS_STATUS_OFS, 32'hFFFF_FFFF);
    rdchk(AETS_STATUS_OFS, 32'h0);
    wr(32'h0000_0010, 32'hFFFF_FFFF);
    rdchk(32'h0000_0010, 32'h0);
    check({31'h0, hresp}, 32'h0);
    // Pin functions set while the converter is still stopped
    wr(AETS_PORT_FN_OFS, 32'hF);
    // Select, one buffer, one trigger; channel field 6 keeps to 0-3
    wr(AETS_MODE_A_OFS, 32'h86);
    s = u_aets_far.seq;
    u_aets_far.fire(4'h1);
    wait_on(1);
    cyc(2);
    check(last_ch, 32'h2);
    check({31'h0, conv_active}, 32'h0);
    chk_res(2, s, 3'h2);
    u_aets_far.fire(4'h2);
    cyc(20);
    check(n_start, 1);
    check(n_irq, 1);
    // Retrigger in mid-conversion
    u_aets_far.lat = 20;
    s = u_aets_far.seq;
    u_aets_far.fire(4'h1);
    cyc(4);
    u_aets_far.fire(4'h1);
    wait_on(1);
    cyc(2);
    check(n_start, 3);
    check(n_irq, 2);
    chk_res(2, s, 3'h2);
    u_aets_far.lat = 6;
    // Select, one buffer, four triggers in scrambled order
    wr(AETS_MODE_B_OFS, 32'h1);
    wr(AETS_MODE_A_OFS, 32'h81);
    for (int i = 0; i < 4; i++) begin
      s = u_aets_far.seq;
      u_aets_far.fire(4'(pa[i]));
      wait_on(1);
      cyc(2);
      chk_res(1, s, 3'h1);
    end
    check(n_irq, 6);
    // Scan four triggers, low group only; two pins at once first
    wr(AETS_MODE_A_OFS, 32'h8B);
    s = u_aets_far.seq;
    ni = n_start;
    u_aets_far.fire(4'h3);
    cyc(12);
    check(last_ch, 32'h0);
    check(n_start, ni + 1);
    ni = n_irq;
    u_aets_far.fire(4'h4);
    cyc(12);
    u_aets_far.fire(4'h8);
    cyc(12);
    check(n_irq, ni);
    u_aets_far.fire(4'h2);
    wait_on(1);
    cyc(2);
    check(n_irq, ni + 1);
    for (int k = 0; k < 4; k++) chk_res(k, s + so[k], 3'(k));
    u_aets_far.fire(4'h4);
    cyc(4);
    check(last_ch, 32'h2);
    // Stopping the converter also clears the half-done set
    wr(AETS_MODE_A_OFS, 32'h0);
    wr(AETS_MODE_B_OFS, 32'h0);
    wr(AETS_MODE_A_OFS, 32'h93);
    s = u_aets_far.seq;
    ni = n_irq;
    u_aets_far.fire(4'h1);
    wait_on(1);
    cyc(2);
    check(n_irq, ni + 1);
    check({31'h0, conv_active}, 32'h0);
    for (int k = 0; k < 4; k++) chk_res(k, s + k, 3'h3);
    // Four buffers, four triggers, done only after the fourth
    wr(AETS_MODE_B_OFS, 32'h1);
    s = u_aets_far.seq;
    for (int i = 0; i < 4; i++) begin
      if (i == 3) check(n_irq, ni + 1);
      u_aets_far.fire(4'(pc[i]));
      cyc(12);
    end
    check(n_irq, ni + 2);
    for (int k = 0; k < 4; k++) chk_res(k, s + sc[k], 3'h3);
    // Full scan, then a retrigger while the high group runs
    wr(AETS_MODE_A_OFS, 32'h0);
    wr(AETS_MODE_B_OFS, 32'h0);
    wr(AETS_MODE_A_OFS, 32'h8F);
    u_aets_far.lat = 10;
    s = u_aets_far.seq;
    ni = n_irq;
    u_aets_far.fire(4'h1);
    wait_on(1);
    cyc(2);
    for (int k = 0; k < 8; k++) chk_res(k, s + k, 3'(k));
    u_aets_far.fire(4'h1);
    wait_on(2);
    u_aets_far.fire(4'h1);
    wait_on(1);
    cyc(2);
    check(n_irq, ni + 2);
    chk_res(0, s + 13, 3'h0);
    chk_res(7, s + 20, 3'h7);
    // A clock-enable gap inside a pin event still yields one start
    ni = n_start;
    fork
      u_aets_far.fire(4'h1);
      begin
        cyc(2);
        ce <= 1'b0;
        cyc(1);
        ce <= 1'b1;
      end
    join
    cyc(2);
    check(n_start, ni + 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
